// ==== design/d2s_setup_regs.sv ====
`timescale 1ns/10ps
// Operation
// - Color pattern lives at pattern base; engine fetches pattern pixels from there.
// - Pattern store holds 16, 32 or 48 doublewords for 8, 16, 24 bpp.
// - Pixels run left to right, then row by row, fully packed.
// - At 8 bpp four pixels per doubleword, first pixel in lowest byte.
// - At 16 bpp two pixels per doubleword, first in low half-word.
// - At 24 bpp 3-byte pixels packed, crossing doubleword boundaries.
// - Source base holds address bits 21-3; low bits zero, top reserved.
// - Source row address is source base plus row times source stride.
// - Destination base holds address bits 21-3 of pixel (0,0); low bits zero.
// - Clip limits apply only while clipping enable is set.
// - Horizontal drawing allowed from left limit to right limit inclusive.
// - Vertical drawing allowed from top limit to bottom limit inclusive.
// - Source stride in bits 11-0 gives byte step between source rows.
// - Destination stride in bits 27-16 gives byte step between destination rows.
// - Mono pattern select takes rows 0-3 from the low mono register.
// - High mono register supplies rows 4-7 of the mono pattern.
// - One byte per row, row pixel 0 at the byte's most significant bit.
// - Base, clip and stride registers appear at all three aliases.
// - Mono registers appear only at the bitblt and polygon aliases.
module d2s_setup_regs
  import d2s_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  // Register port
  input  wire logic [ADDR_W-1:0]    regAddr,
  input  wire logic [31:0]          regWrData,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [31:0]          regRdData,
  // Drawing engine queries
  input  wire logic                 engClipEn,
  input  wire logic [FIELD11_W-1:0] engX,
  input  wire logic [FIELD11_W-1:0] engY,
  input  wire logic [1:0]           engFormat,
  input  wire logic [2:0]           engPatX,
  input  wire logic [2:0]           engPatY,
  // Drawing engine answers
  output logic                      clipPass,
  output logic      [23:0]          patPixel,
  output logic                      monoBit,
  output logic      [VADDR_W-1:0]   srcRowAddr,
  output logic      [VADDR_W-1:0]   dstRowAddr
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Map a byte address onto one physical register, any alias
  function automatic d2s_reg_type decodeReg(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] rel;
    decodeReg = REG_NONE;
    for (int a = 0; a < 3; a++) begin
      case (a)
        0:       rel = addr - BLT_ALIAS_DELTA;
        1:       rel = addr - LINE_ALIAS_DELTA;
        default: rel = addr - POLY_ALIAS_DELTA;
      endcase
      if (rel == SOURCE_BASE_ADDRESS_OFS) decodeReg = REG_SRC;
      if (rel == DST_BASE_OFS) decodeReg = REG_DST;
      if (rel == HCLIP_OFS) decodeReg = REG_HCLIP;
      if (rel == VCLIP_OFS) decodeReg = REG_VCLIP;
      if (rel == STRIDE_OFS) decodeReg = REG_STR;
      if (a != 1 && rel == MONO_LOW_OFS) decodeReg = REG_MLOW;
      if (a != 1 && rel == MONO_HIGH_OFS) decodeReg = REG_MHIGH;
    end
    if (addr >= PAT_BASE_OFS && addr <= PAT_END_OFS && addr[1:0] == 2'b00) begin
      decodeReg = REG_PAT;
    end
  endfunction : decodeReg

  // Word index inside the pattern store
  function automatic logic [5:0] patIndex(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] rel;
    rel = addr - PAT_BASE_OFS;
    patIndex = rel[7:2];
  endfunction : patIndex

  d2s_reg_type regSel;
  logic [5:0]  patWordSel;

  // Decode once for both strobes
  assign regSel     = decodeReg(regAddr);
  assign patWordSel = patIndex(regAddr);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [31:0] srcBase_reg;
  logic [31:0] dstBase_reg;
  logic [31:0] hClip_reg;
  logic [31:0] vClip_reg;
  logic [31:0] stride_reg;
  logic [31:0] monoLow_reg;
  logic [31:0] monoHigh_reg;
  logic [31:0] patMem [PAT_WORDS_24];

  // Base addresses keep only the quadword address bits
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      srcBase_reg <= REG_RESET_VAL;
      dstBase_reg <= REG_RESET_VAL;
    end else if (regWr) begin
      if (regSel == REG_SRC) srcBase_reg <= regWrData & BASE_MASK;
      if (regSel == REG_DST) dstBase_reg <= regWrData & BASE_MASK;
    end
  end

  // Clip limits and strides, reserved bits dropped
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hClip_reg  <= REG_RESET_VAL;
      vClip_reg  <= REG_RESET_VAL;
      stride_reg <= REG_RESET_VAL;
    end else if (regWr) begin
      if (regSel == REG_HCLIP) hClip_reg <= regWrData & CLIP_MASK;
      if (regSel == REG_VCLIP) vClip_reg <= regWrData & CLIP_MASK;
      if (regSel == REG_STR) stride_reg <= regWrData & STRIDE_MASK;
    end
  end

  // Mono pattern halves
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      monoLow_reg  <= REG_RESET_VAL;
      monoHigh_reg <= REG_RESET_VAL;
    end else if (regWr) begin
      if (regSel == REG_MLOW) monoLow_reg <= regWrData & MONO_MASK;
      if (regSel == REG_MHIGH) monoHigh_reg <= regWrData & MONO_MASK;
    end
  end

  // Color pattern store, one flop word per doubleword
  generate
    for (genvar w = 0; w < PAT_WORDS_24; w++) begin : g_pat
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          patMem[w] <= REG_RESET_VAL;
        end else if (regWr && regSel == REG_PAT && patWordSel == 6'(w)) begin
          patMem[w] <= regWrData;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [31:0] rdMux;

  // Select the addressed word; unmapped reads return zero
  always_comb begin
    case (regSel)
      REG_SRC:   rdMux = srcBase_reg;
      REG_DST:   rdMux = dstBase_reg;
      REG_HCLIP: rdMux = hClip_reg;
      REG_VCLIP: rdMux = vClip_reg;
      REG_STR:   rdMux = stride_reg;
      REG_MLOW:  rdMux = monoLow_reg;
      REG_MHIGH: rdMux = monoHigh_reg;
      REG_PAT:   rdMux = patMem[patWordSel];
      default:   rdMux = 32'h0000_0000;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 32'h0000_0000;
    end else if (regRd) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Clipping test
  // ----------------------------------------------------------------
  logic [FIELD11_W-1:0] clipLeft;
  logic [FIELD11_W-1:0] clipRight;
  logic [FIELD11_W-1:0] clipTop;
  logic [FIELD11_W-1:0] clipBottom;
  logic                 clipPass_next;

  // Field extraction from the clip registers
  assign clipLeft   = hClip_reg[CLIP_HI_LSB +: FIELD11_W];
  assign clipRight  = hClip_reg[FIELD11_W-1:0];
  assign clipTop    = vClip_reg[CLIP_HI_LSB +: FIELD11_W];
  assign clipBottom = vClip_reg[FIELD11_W-1:0];

  // Inclusive window, bypassed while clipping is off
  always_comb begin
    if (!engClipEn) begin
      clipPass_next = 1'b1;
    end else begin
      clipPass_next = (engX >= clipLeft) && (engX <= clipRight)
                   && (engY >= clipTop) && (engY <= clipBottom);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clipPass <= 1'b0;
    end else begin
      clipPass <= clipPass_next;
    end
  end

  // ----------------------------------------------------------------
  // Row addresses
  // ----------------------------------------------------------------
  logic [FIELD12_W-1:0] srcStride;
  logic [FIELD12_W-1:0] dstStride;
  logic [VADDR_W-1:0]   srcRow_next;
  logic [VADDR_W-1:0]   dstRow_next;

  assign srcStride = stride_reg[FIELD12_W-1:0];
  assign dstStride = stride_reg[STRIDE_DST_LSB +: FIELD12_W];

  // Pixel (0,0) at the base, one stride per row
  always_comb begin
    srcRow_next = srcBase_reg[VADDR_W-1:0] + VADDR_W'(engY * srcStride);
    dstRow_next = dstBase_reg[VADDR_W-1:0] + VADDR_W'(engY * dstStride);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      srcRowAddr <= '0;
      dstRowAddr <= '0;
    end else begin
      srcRowAddr <= srcRow_next;
      dstRowAddr <= dstRow_next;
    end
  end

  // ----------------------------------------------------------------
  // Color pattern fetch
  // ----------------------------------------------------------------
  logic [5:0]  pixNum;
  logic [7:0]  byteOfs;
  logic [5:0]  word24;
  logic [31:0] word24Next;
  logic [63:0] pair24;
  logic [23:0] patPixel_next;

  // Linear pixel number: row major from the upper left
  assign pixNum  = {engPatY, engPatX};
  assign byteOfs = 8'(pixNum * 3);
  assign word24  = byteOfs[7:2];

  always_comb begin
    word24Next = (word24 == 6'(PAT_WORDS_24 - 1)) ? 32'h0000_0000 : patMem[word24 + 6'h01];
    pair24     = {word24Next, patMem[word24]} >> {byteOfs[1:0], 3'b000};
    case (d2s_fmt_type'(engFormat))
      FMT_8BPP:  patPixel_next = {16'h0000,
                                  8'(patMem[pixNum[5:2]] >> {pixNum[1:0], 3'b000})};
      FMT_16BPP: patPixel_next = {8'h00,
                                  16'(patMem[pixNum[5:1]] >> {pixNum[0], 4'h0})};
      FMT_24BPP: patPixel_next = pair24[23:0];
      default:   patPixel_next = 24'h00_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      patPixel <= 24'h00_0000;
    end else begin
      patPixel <= patPixel_next;
    end
  end

  // ----------------------------------------------------------------
  // Mono pattern fetch
  // ----------------------------------------------------------------
  logic [31:0] monoHalf;
  logic [4:0]  monoBitPos;

  // Rows 0-3 in the low half, rows 4-7 in the high half
  assign monoHalf   = engPatY[2] ? monoHigh_reg : monoLow_reg;
  assign monoBitPos = {engPatY[1:0], ~engPatX};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      monoBit <= 1'b0;
    end else begin
      monoBit <= monoHalf[monoBitPos];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence srcWriteSeq;
    regWr && decodeReg(regAddr) == REG_SRC;
  endsequence

  sequence readBackSeq;
    ##1 (regRd && decodeReg(regAddr) == REG_SRC && !regWr) ##1 1'b1;
  endsequence

  alias_readback_a: assert property (
    srcWriteSeq ##0 readBackSeq |-> regRdData == ($past(regWrData, 2) & BASE_MASK))
    else $error("source base read back differs from alias write");

  base_low_zero_a: assert property (
    $rose(regWr) || 1'b1 |-> srcBase_reg[2:0] == 3'b000 && srcBase_reg[31:22] == 10'h000)
    else $error("source base holds non-address bits");

  dst_write_a: assert property (
    regWr && decodeReg(regAddr) == REG_DST |=> dstBase_reg == ($past(regWrData) & BASE_MASK))
    else $error("destination base not updated");

  clip_off_a: assert property (
    !engClipEn |=> clipPass)
    else $error("pixel clipped while clipping disabled");

  clip_left_a: assert property (
    engClipEn && engX < clipLeft && !regWr |=> !clipPass)
    else $error("pixel left of clip window passed");

  clip_bottom_a: assert property (
    engClipEn && engY > clipBottom && !regWr |=> !clipPass)
    else $error("line below clip window passed");

  line_no_mono_a: assert property (
    regRd && regAddr == MONO_LOW_OFS + LINE_ALIAS_DELTA |=> regRdData == 32'h0000_0000)
    else $error("mono pattern visible at line alias");

  mono_row_a: assert property (
    engPatY == 3'd0 && engPatX == 3'd0 && !regWr |=> monoBit == monoLow_reg[7])
    else $error("mono pixel 0 of row 0 not at bit 7");

  pat8_pixel_a: assert property (
    engFormat == 2'b00 && pixNum == 6'd5 && !regWr |=> patPixel == {16'h0000, patMem[1][15:8]})
    else $error("8 bpp pattern pixel misplaced");

  src_row_a: assert property (
    engY == 11'd0 && !regWr |=> srcRowAddr == srcBase_reg[VADDR_W-1:0])
    else $error("source row 0 not at source base");

  dst_row_a: assert property (
    engY == 11'd0 && !regWr |=> dstRowAddr == dstBase_reg[VADDR_W-1:0])
    else $error("destination row 0 not at destination base");

  clip_right_a: assert property (
    engClipEn && engX > clipRight && !regWr |=> !clipPass)
    else $error("pixel right of clip window passed");

  clip_top_a: assert property (
    engClipEn && engY < clipTop && !regWr |=> !clipPass)
    else $error("line above clip window passed");

  read_idle_a: assert property (
    !regRd |=> regRdData == 32'h0000_0000)
    else $error("read data shown without a read strobe");

  pat16_pixel_a: assert property (
    engFormat == 2'b01 && pixNum == 6'd3 && !regWr |=> patPixel == {8'h00, patMem[1][31:16]})
    else $error("16 bpp pattern pixel misplaced");

  pat24_pixel_a: assert property (
    engFormat == 2'b10 && pixNum == 6'd1 && !regWr
    |=> patPixel == {patMem[1][15:0], patMem[0][31:24]})
    else $error("24 bpp pattern pixel misplaced");

  mono_high_a: assert property (
    engPatY == 3'd4 && engPatX == 3'd7 && !regWr |=> monoBit == monoHigh_reg[0])
    else $error("mono pixel 7 of row 4 not at high bit 0");

endmodule : d2s_setup_regs

// ==== inc/d2s_pkg.sv ====
package d2s_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned   ADDR_W          = 28;
  localparam logic [27:0]   SOURCE_BASE_ADDRESS_OFS    = 28'h000a4d4;
  localparam logic [27:0]   DST_BASE_OFS    = 28'h000a4d8;
  localparam logic [27:0]   HCLIP_OFS       = 28'h000a4dc;
  localparam logic [27:0]   VCLIP_OFS       = 28'h000a4e0;
  localparam logic [27:0]   STRIDE_OFS      = 28'h000a4e4;
  localparam logic [27:0]   MONO_LOW_OFS    = 28'h000a4e8;
  localparam logic [27:0]   MONO_HIGH_OFS   = 28'h000a4ec;
  localparam logic [27:0]   PAT_BASE_OFS    = 28'h100a100;
  // Distance of each command set alias from the bitblt copy
  localparam logic [27:0]   BLT_ALIAS_DELTA  = 28'h0000000;
  localparam logic [27:0]   LINE_ALIAS_DELTA = 28'h0000400;
  localparam logic [27:0]   POLY_ALIAS_DELTA = 28'h0000800;

  // ----------------------------------------------------------------
  // Pattern store size and field layout
  // ----------------------------------------------------------------
  localparam int unsigned   PAT_WORDS_8     = 16;
  localparam int unsigned   PAT_WORDS_16    = 32;
  localparam int unsigned   PAT_WORDS_24    = 48;
  localparam logic [27:0]   PAT_END_OFS     = 28'h100a1bc;
  localparam logic [31:0]   BASE_MASK       = 32'h003f_fff8;
  localparam logic [31:0]   CLIP_MASK       = 32'h07ff_07ff;
  localparam logic [31:0]   STRIDE_MASK     = 32'h0fff_0fff;
  localparam logic [31:0]   MONO_MASK       = 32'hffff_ffff;
  localparam int unsigned   CLIP_HI_LSB     = 16;
  localparam int unsigned   STRIDE_DST_LSB  = 16;
  localparam int unsigned   FIELD11_W       = 11;
  localparam int unsigned   FIELD12_W       = 12;
  localparam int unsigned   VADDR_W         = 22;

  // ----------------------------------------------------------------
  // Values after reset (undefined by the hardware, cleared here)
  // ----------------------------------------------------------------
  localparam logic [31:0]   REG_RESET_VAL   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    REG_NONE  = 4'b0000,
    REG_SRC   = 4'b0001,
    REG_DST   = 4'b0010,
    REG_HCLIP = 4'b0011,
    REG_VCLIP = 4'b0100,
    REG_STR   = 4'b0101,
    REG_MLOW  = 4'b0110,
    REG_MHIGH = 4'b0111,
    REG_PAT   = 4'b1000
  } d2s_reg_type;

  typedef enum logic [1:0] {
    FMT_8BPP  = 2'b00,
    FMT_16BPP = 2'b01,
    FMT_24BPP = 2'b10,
    FMT_RSVD  = 2'b11
  } d2s_fmt_type;

endpackage : d2s_pkg

// ==== sim/d2s_setup_regs_bench.sv ====
`timescale 1ns/10ps
module d2s_setup_regs_bench;
  import d2s_pkg::*;

  // ------------------------------------------------------------
  // Signals and tables
  // ------------------------------------------------------------
  logic              ref_clk;
  logic              nrst;
  logic [ADDR_W-1:0] regAddr;
  logic [31:0]       regWrData;
  logic              regWr;
  logic              regRd;
  logic [31:0]       regRdData;
  logic              engClipEn;
  logic [10:0]       engX;
  logic [10:0]       engY;
  logic [1:0]        engFormat;
  logic [2:0]        engPatX;
  logic [2:0]        engPatY;
  logic              clipPass;
  logic [23:0]       patPixel;
  logic              monoBit;
  logic [21:0]       srcRowAddr;
  logic [21:0]       dstRowAddr;
  int                badCount;
  int                checked;
  localparam logic [27:0] OFS_TAB [5] = '{SOURCE_BASE_ADDRESS_OFS, DST_BASE_OFS, HCLIP_OFS,
                                          VCLIP_OFS, STRIDE_OFS};
  localparam logic [31:0] MSK_TAB [5] = '{BASE_MASK, BASE_MASK, CLIP_MASK,
                                          CLIP_MASK, STRIDE_MASK};
  // Bits software may set; stride steps stay quadword multiples
  localparam logic [31:0] LEGAL_TAB [5] = '{BASE_MASK, BASE_MASK, CLIP_MASK,
                                            CLIP_MASK, STRIDE_MASK & 32'hfff8_fff8};
  localparam logic [27:0] ALI_TAB [3] = '{BLT_ALIAS_DELTA, LINE_ALIAS_DELTA,
                                          POLY_ALIAS_DELTA};
  localparam logic [31:0] MONO_LO = 32'hc3a5_0f81;
  localparam logic [31:0] MONO_HI = 32'h7e18_f00d;

  // Device under test
  d2s_setup_regs uut (
    .ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .engClipEn(engClipEn),
    .engX(engX), .engY(engY), .engFormat(engFormat), .engPatX(engPatX),
    .engPatY(engPatY), .clipPass(clipPass), .patPixel(patPixel),
    .monoBit(monoBit), .srcRowAddr(srcRowAddr), .dstRowAddr(dstRowAddr)
  );

  // ------------------------------------------------------------
  // Clock, reset and watchdog
  // ------------------------------------------------------------
  always #20 ref_clk = ~ref_clk;

  // Cuts a hang well beyond the expected run of about 1100 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    badCount++;
    finish_test();
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit

  // One-cycle write strobe
  task automatic reg_write(input logic [27:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge ref_clk);
    regWr     <= 1'b0;
  endtask : reg_write

  // One-cycle read strobe; data stands only in the following cycle
  task automatic reg_read(input logic [27:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd   <= 1'b0;
    #1;
    chk_word(regRdData, exp, "read data");
    @(posedge ref_clk);
    #1;
    chk_word(regRdData, 32'h0, "read idle");
  endtask : reg_read

  // Write strobe followed at once by a read strobe, no idle cycle between
  task automatic reg_wr_rd(input logic [27:0] wa, input logic [31:0] d,
                           input logic [27:0] ra, input logic [31:0] exp);
    @(posedge ref_clk);
    regAddr   <= wa;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge ref_clk);
    regWr     <= 1'b0;
    regAddr   <= ra;
    regRd     <= 1'b1;
    @(posedge ref_clk);
    regRd     <= 1'b0;
    #1;
    chk_word(regRdData, exp, "read after write");
    @(posedge ref_clk);
    #1;
    chk_word(regRdData, 32'h0, "read idle");
  endtask : reg_wr_rd

  // Present an engine query and wait for its registered answer
  task automatic eng_apply(input logic en, input logic [10:0] x, input logic [10:0] y,
                           input logic [1:0] f, input logic [2:0] px, input logic [2:0] py);
    @(posedge ref_clk);
    engClipEn <= en;
    engX      <= x;
    engY      <= y;
    engFormat <= f;
    engPatX   <= px;
    engPatY   <= py;
    @(posedge ref_clk);
    #1;
  endtask : eng_apply

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // Expected pattern pixel when pattern byte k holds value k
  function automatic logic [23:0] pat_exp(input int f, input int n);
    case (f)
      0:       return {16'h0, 8'(n)};
      1:       return {8'h0, 8'(2*n+1), 8'(2*n)};
      2:       return {8'(3*n+2), 8'(3*n+1), 8'(3*n)};
      default: return 24'h0;
    endcase
  endfunction : pat_exp

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [31:0] mono;
    logic [10:0] ys [4];
    logic [27:0] ra;
    ref_clk = 1'b0; nrst = 1'b0; regAddr = 28'h0; regWrData = 32'h0;
    regWr = 1'b0; regRd = 1'b0; engClipEn = 1'b0; engX = 11'h0; engY = 11'h0;
    engFormat = 2'h0; engPatX = 3'h0; engPatY = 3'h0; badCount = 0; checked = 0;
    ys = '{11'h000, 11'h001, 11'h007, 11'h7ff};
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    // Each shared register written at one alias, read at the next
    for (int r = 0; r < 5; r++) begin
      for (int a = 0; a < 3; a++) begin
        d = (a == 0) ? 32'hffff_ffff : (32'h5a3c_96e8 ^ 32'(r * 3 + a));
        d = d & LEGAL_TAB[r];
        ra = OFS_TAB[r] + ALI_TAB[(a + 1) % 3];
        reg_wr_rd(OFS_TAB[r] + ALI_TAB[a], d, ra, d & MSK_TAB[r]);
      end
    end
    // Mono pattern halves: bitblt and polygon aliases only
    reg_write(MONO_LOW_OFS, MONO_LO);
    reg_write(MONO_HIGH_OFS + POLY_ALIAS_DELTA, MONO_HI);
    reg_write(MONO_LOW_OFS + LINE_ALIAS_DELTA, 32'hffff_ffff);
    reg_read(MONO_LOW_OFS + POLY_ALIAS_DELTA, MONO_LO);
    reg_read(MONO_HIGH_OFS, MONO_HI);
    reg_read(MONO_LOW_OFS + LINE_ALIAS_DELTA, 32'h0);
    // Unmapped and unaligned places are ignored and read zero
    reg_write(SOURCE_BASE_ADDRESS_OFS, 32'h0000_1238);
    reg_write(28'h000a4d6, 32'hffff_ffff);
    reg_write(28'h000a4f0, 32'hffff_ffff);
    reg_read(SOURCE_BASE_ADDRESS_OFS + LINE_ALIAS_DELTA, 32'h0000_1238);
    reg_read(28'h000a4f0, 32'h0);
    reg_read(PAT_END_OFS + 28'h4, 32'h0);
    // Fill the whole pattern store so that byte k holds value k
    for (int i = 0; i < PAT_WORDS_24; i++) begin
      d = {8'(4*i+3), 8'(4*i+2), 8'(4*i+1), 8'(4*i)};
      reg_write(PAT_BASE_OFS + 28'(4 * i), d);
    end
    for (int i = 0; i < PAT_WORDS_24; i++) begin
      d = {8'(4*i+3), 8'(4*i+2), 8'(4*i+1), 8'(4*i)};
      reg_read(PAT_BASE_OFS + 28'(4 * i), d);
    end
    // Pattern pixels in every format, mono bits alongside
    for (int f = 0; f < 4; f++) begin
      for (int n = 0; n < 64; n++) begin
        eng_apply(1'b0, 11'h0, 11'h0, 2'(f), 3'(n % 8), 3'(n / 8));
        chk_word({8'h0, patPixel}, {8'h0, pat_exp(f, n)}, "pattern");
        mono = (n < 32) ? MONO_LO : MONO_HI;
        chk_bit(monoBit, mono[((n / 8) % 4) * 8 + 7 - (n % 8)], "mono bit");
      end
    end
    // Clipping window left 6 right 9, top 3 bottom 4
    reg_write(HCLIP_OFS, 32'h0006_0009);
    reg_write(VCLIP_OFS + POLY_ALIAS_DELTA, 32'h0003_0004);
    for (int en = 0; en < 2; en++) begin
      for (int x = 4; x < 12; x++) begin
        for (int y = 1; y < 7; y++) begin
          eng_apply(1'(en), 11'(x), 11'(y), 2'h0, 3'h0, 3'h0);
          d = 32'((en == 0) || (x >= 6 && x <= 9 && y >= 3 && y <= 4));
          chk_bit(clipPass, d[0], "clip");
        end
      end
    end
    // Full-width window with top and bottom both at 7ff reaches the last 11-bit position
    reg_write(HCLIP_OFS + LINE_ALIAS_DELTA, 32'h0000_07ff);
    reg_write(VCLIP_OFS, 32'h07ff_07ff);
    eng_apply(1'b1, 11'h7ff, 11'h7ff, 2'h0, 3'h0, 3'h0);
    chk_bit(clipPass, 1'b1, "clip edge");
    eng_apply(1'b1, 11'h7ff, 11'h7fe, 2'h0, 3'h0, 3'h0);
    chk_bit(clipPass, 1'b0, "clip edge");
    // Row addresses from bases and strides, destination wrapping at 22 bits
    reg_write(SOURCE_BASE_ADDRESS_OFS + LINE_ALIAS_DELTA, 32'h0001_2348);
    reg_write(DST_BASE_OFS + POLY_ALIAS_DELTA, 32'h003f_0000);
    reg_write(STRIDE_OFS, 32'h0140_00a0);
    for (int k = 0; k < 4; k++) begin
      eng_apply(1'b0, 11'h0, ys[k], 2'h0, 3'h0, 3'h0);
      d = {10'h0, 22'(32'h0001_2348 + 32'(ys[k]) * 32'h0a0)};
      chk_word({10'h0, srcRowAddr}, d, "src row");
      d = {10'h0, 22'(32'h003f_0000 + 32'(ys[k]) * 32'h140)};
      chk_word({10'h0, dstRowAddr}, d, "dst row");
    end
    finish_test();
  end

endmodule : d2s_setup_regs_bench
